// [dpram_defines.svh]
// Constants for the dual-port memory block
`ifndef DPRAM_DEFINES_SVH
`define DPRAM_DEFINES_SVH

// Storage size in bits
`define DPRAM_TOTAL_BITS 256
// Address and data bus widths
`define DPRAM_ADDR_W 6
`define DPRAM_DATA_W 8
// Width of one narrow word
`define DPRAM_NIB_W 4
// Word counts of the two arrangements
`define DPRAM_DEPTH_X4 64
`define DPRAM_DEPTH_X8 32
// Reset value of the read data output
`define DPRAM_RD_RESET 8'h00

`endif

// [dpram_pkg.sv]
// Types shared by the dual-port memory block
package dpram_pkg;

    // Word arrangement, one-hot coded
    typedef enum logic [1:0] {
        WIDTH_X4 = 2'b01,
        WIDTH_X8 = 2'b10
    } width_mode_e;

endpackage

// [port_edge_detect.sv]
// Active edge detector for one port clock sampled by the core clock
`timescale 1ns/1ps
`include "dpram_defines.svh"

module port_edge_detect (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Port clock and its polarity choice
    input wire logic portClk,
    input wire logic fallEdge,
    // One-cycle pulse on the chosen edge
    output logic activeEdge
);

    logic prevClk;
    logic armed;

    // Previous sample; armed blocks a false edge right after reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prevClk <= 1'b0;
            armed <= 1'b0;
        end else begin
            prevClk <= portClk;
            armed <= 1'b1;
        end
    end

    // Rising or falling edge as configured
    always_comb begin
        if (fallEdge) begin
            activeEdge = armed & prevClk & ~portClk;
        end else begin
            activeEdge = armed & ~prevClk & portClk;
        end
    end

endmodule

// [dual_port_ram_block.sv]
// 256-bit dual-port memory block, 64x4 or 32x8
`timescale 1ns/1ps
`include "dpram_defines.svh"

// Overview of operation
// - Holds 256 bits, arranged as 64 words of 4 or 32 of 8.
// - Separate write and read ports work independently and concurrently.
// - Each port takes a six-bit address selecting one of 64 nibbles.
// - In byte arrangement the top address bit of both ports is ignored.
// - Each port has its own clock with selectable active edge.
// - Eight-bit write and read data; 4-bit arrangement uses low bits.
module dual_port_ram_block #(
    parameter int ADDR_W = `DPRAM_ADDR_W,
    parameter int DATA_W = `DPRAM_DATA_W,
    parameter int NIB_W = `DPRAM_NIB_W,
    parameter int DEPTH = `DPRAM_DEPTH_X4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Configuration
    input wire dpram_pkg::width_mode_e widthMode,
    input wire logic writeFallEdge,
    input wire logic readFallEdge,
    // Write port
    input wire logic writeClk,
    input wire logic writeEnable,
    input wire logic [ADDR_W-1:0] write_address,
    input wire logic [DATA_W-1:0] write_data_in,
    // Read port
    input wire logic readClk,
    input wire logic readEnable,
    input wire logic [ADDR_W-1:0] read_address,
    output logic [DATA_W-1:0] readData,
    output logic readStrobe
);

    ////////////////////////////////////////////////////////////////////////
    // Storage and helpers

    // Storage kept as narrow words; a byte uses an even/odd pair
    logic [NIB_W-1:0] mem [0:DEPTH-1];

    logic writeEvt;
    logic readEvt;
    logic doWrite;
    logic doRead;

    // Nibble index: byte arrangement drops the top address bit
    function automatic logic [ADDR_W-1:0] nibIdx(
        input logic [ADDR_W-1:0] addr,
        input dpram_pkg::width_mode_e mode,
        input logic upper
    );
        logic [ADDR_W-1:0] idx;
        idx = addr;
        if (mode == dpram_pkg::WIDTH_X8) begin
            idx = {addr[ADDR_W-2:0], upper};
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Port clock edges

    // Write port edge, own polarity
    port_edge_detect u_wr_edge (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .portClk(writeClk),
        .fallEdge(writeFallEdge),
        .activeEdge(writeEvt)
    );

    // Read port edge, own polarity
    port_edge_detect u_rd_edge (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .portClk(readClk),
        .fallEdge(readFallEdge),
        .activeEdge(readEvt)
    );

    // Qualified port operations
    assign doWrite = writeEvt & writeEnable;
    assign doRead = readEvt & readEnable;

    ////////////////////////////////////////////////////////////////////////
    // Write port

    // Memory has no reset, like the real array
    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            mem[nibIdx(write_address, widthMode, 1'b0)] <=
                write_data_in[NIB_W-1:0];
            if (widthMode == dpram_pkg::WIDTH_X8) begin
                mem[nibIdx(write_address, widthMode, 1'b1)] <=
                    write_data_in[DATA_W-1:NIB_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    // Runs alongside the write port; same-slot collision reads old data
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readData <= `DPRAM_RD_RESET;
        end else if (doRead) begin
            if (widthMode == dpram_pkg::WIDTH_X8) begin
                readData <= {mem[nibIdx(read_address, widthMode, 1'b1)],
                    mem[nibIdx(read_address, widthMode, 1'b0)]};
            end else begin
                readData <= {{(DATA_W-NIB_W){1'b0}},
                    mem[nibIdx(read_address, widthMode, 1'b0)]};
            end
        end
    end

    // Marks the cycle after a read update
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readStrobe <= 1'b0;
        end else begin
            readStrobe <= doRead;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checking helpers

    // Last write remembered to check a later read of the same slot
    logic lastValid;
    logic [ADDR_W-1:0] lastAddr;
    logic [DATA_W-1:0] lastData;
    dpram_pkg::width_mode_e lastMode;
    logic hitRead;
    logic [DATA_W-1:0] expData;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lastValid <= 1'b0;
            lastAddr <= '0;
            lastData <= '0;
            lastMode <= dpram_pkg::WIDTH_X4;
        end else if (doWrite) begin
            lastValid <= 1'b1;
            lastAddr <= write_address;
            lastData <= write_data_in;
            lastMode <= widthMode;
        end
    end

    // Read that must return the last write, given unchanged arrangement
    always_comb begin
        hitRead = lastValid && doRead && !doWrite &&
            (lastMode == widthMode) &&
            (nibIdx(read_address, widthMode, 1'b0) ==
             nibIdx(lastAddr, lastMode, 1'b0));
        if (widthMode == dpram_pkg::WIDTH_X8) begin
            expData = lastData;
        end else begin
            expData = {{(DATA_W-NIB_W){1'b0}}, lastData[NIB_W-1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Storage width matches the two arrangements
    initial begin
        chk_storage_size: assert (DEPTH * NIB_W == `DPRAM_TOTAL_BITS)
        else $error("storage is not 256 bits");
    end

    chk_readback_last: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        hitRead |=> (readData == $past(expData)))
    else $error("read did not return last written word");

    // Port clocks toggle, so two reads of one byte lie two cycles apart
    chk_byte_alias: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (doRead && widthMode == dpram_pkg::WIDTH_X8 && $past(doRead, 2) &&
         !$past(doRead) && $past(widthMode, 2) == dpram_pkg::WIDTH_X8 &&
         read_address[ADDR_W-2:0] == $past(read_address[ADDR_W-2:0], 2) &&
         !$past(doWrite) && !$past(doWrite, 2))
        |=> $stable(readData))
    else $error("byte read depends on top address bit");

    chk_nibble_upper: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (doRead && widthMode == dpram_pkg::WIDTH_X4)
        |=> (readData[DATA_W-1:NIB_W] == '0))
    else $error("upper read bits not zero in nibble arrangement");

    chk_read_update: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        doRead |=> readStrobe ##1 !readStrobe || $past(doRead))
    else $error("read strobe missing after enabled read edge");

    chk_read_hold: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !doRead |=> $stable(readData) && !readStrobe)
    else $error("read data changed without enabled read edge");

    chk_both_ports: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (doWrite && doRead) |=> readStrobe && lastValid &&
            lastAddr == $past(write_address))
    else $error("concurrent write and read not both served");

    chk_edge_level: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        readEvt |-> (readClk == !readFallEdge) &&
            ($past(readClk) == readFallEdge))
    else $error("read edge does not match chosen polarity");

    chk_edge_single: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (writeEvt && $stable(writeFallEdge)) |=> !writeEvt)
    else $error("write edge pulse longer than one cycle");

endmodule

// [array_user_logic.sv]
// Model of the array user logic that drives both memory ports
`timescale 1ns/1ps

module array_user_logic (
    // Clock
    input wire logic core_clk,
    // Port clock polarity
    output logic writeFallEdge,
    output logic readFallEdge,
    // Write port
    output logic writeClk,
    output logic writeEnable,
    output logic [5:0] write_address,
    output logic [7:0] write_data_in,
    // Read port
    output logic readClk,
    output logic readEnable,
    output logic [5:0] read_address
);
    // Idle at time zero, rising edges, ports disabled
    initial begin
        writeFallEdge = 1'b0;
        readFallEdge = 1'b0;
        writeClk = 1'b0;
        readClk = 1'b0;
        writeEnable = 1'b0;
        readEnable = 1'b0;
        write_address = 6'h00;
        write_data_in = 8'h00;
        read_address = 6'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Polarity change with enables low, so a stray edge does nothing
    task automatic set_pol(input logic wf, input logic rf);
        @(negedge core_clk);
        writeFallEdge = wf;
        readFallEdge = rf;
        writeClk = wf;
        readClk = rf;
        repeat (2) @(negedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One active edge on each selected port, each level held one core cycle
    task automatic pulse(input logic doW, input logic wen,
        input logic [5:0] wa, input logic [7:0] wd,
        input logic doR, input logic ren, input logic [5:0] ra);
        @(negedge core_clk);
        if (doW) begin
            writeClk = ~writeFallEdge;
            writeEnable = wen;
            write_address = wa;
            write_data_in = wd;
        end
        if (doR) begin
            readClk = ~readFallEdge;
            readEnable = ren;
            read_address = ra;
        end
        @(negedge core_clk);
        // Released lines show the inverse, never the stale value
        writeClk = writeFallEdge;
        readClk = readFallEdge;
        writeEnable = 1'b0;
        readEnable = 1'b0;
        write_address = ~wa;
        write_data_in = ~wd;
        read_address = ~ra;
    endtask
endmodule

// [tb_dual_port_ram_block.sv]
// Self-checking bench for the dual-port memory block
`timescale 1ns/1ps

module tb_dual_port_ram_block;
    logic core_clk;
    logic arst_n;
    dpram_pkg::width_mode_e widthMode;
    logic writeFallEdge, readFallEdge, writeClk, writeEnable;
    logic readClk, readEnable, readStrobe;
    logic [5:0] write_address, read_address;
    logic [7:0] write_data_in, readData;
    logic [7:0] laneData;
    logic laneStrobe;
    logic [3:0] nib [64];
    int err_total;
    int comparisons;

    ////////////////////////////////////////////////////////////////////////
    // Far side and block under test
    array_user_logic ap (.core_clk, .writeFallEdge, .readFallEdge,
        .writeClk, .writeEnable, .write_address, .write_data_in,
        .readClk, .readEnable, .read_address);
    dual_port_ram_block dut (.core_clk, .arst_n, .widthMode,
        .writeFallEdge, .readFallEdge, .writeClk, .writeEnable,
        .write_address, .write_data_in, .readClk, .readEnable,
        .read_address, .readData, .readStrobe);
    // Second block beside the first: shared addresses, other byte lane
    dual_port_ram_block lane (.core_clk, .arst_n, .widthMode,
        .writeFallEdge, .readFallEdge, .writeClk, .writeEnable,
        .write_address, .write_data_in(~write_data_in), .readClk,
        .readEnable, .read_address, .readData(laneData),
        .readStrobe(laneStrobe));

    // 50 MHz core clock
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    // Expected word from the nibble model, per arrangement
    function automatic logic [7:0] word_of(input logic [5:0] a);
        if (widthMode == dpram_pkg::WIDTH_X8) begin
            return {nib[{a[4:0], 1'b1}], nib[{a[4:0], 1'b0}]};
        end
        return {4'h0, nib[a]};
    endfunction

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        ap.pulse(1'b1, 1'b1, a, d, 1'b0, 1'b0, 6'h00);
        if (widthMode == dpram_pkg::WIDTH_X8) begin
            nib[{a[4:0], 1'b0}] = d[3:0];
            nib[{a[4:0], 1'b1}] = d[7:4];
        end else begin
            nib[a] = d[3:0];
        end
    endtask

    task automatic rd(input logic [5:0] a);
        ap.pulse(1'b0, 1'b0, 6'h00, 8'h00, 1'b1, 1'b1, a);
        check({7'h00, readStrobe}, 8'h01);
        check(readData, word_of(a));
        check(laneData, word_of(a) ^ ((widthMode == dpram_pkg::WIDTH_X8) ?
            8'hFF : 8'h0F));
        check({7'h00, laneStrobe}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read side quiet around reset
    task automatic t_reset;
        check(readData, 8'h00);
        check({7'h00, readStrobe}, 8'h00);
    endtask

    // Every nibble; upper data bits must not leak out
    task automatic t_fill_x4;
        for (int i = 0; i < 64; i++) begin
            wr(6'(i), {4'(i), 4'(i ^ (i >> 2))});
        end
        for (int i = 63; i >= 0; i--) begin
            rd(6'(i));
        end
    endtask

    // Bytes on falling edges; top address bit must be ignored
    task automatic t_x8_fall;
        ap.set_pol(1'b1, 1'b1);
        widthMode = dpram_pkg::WIDTH_X8;
        for (int i = 0; i < 32; i++) begin
            rd(6'(i) | 6'h20);
        end
        wr(6'h25, 8'hC3);
        rd(6'h05);
        rd(6'h25);
    endtask

    // Disabled edges change neither memory nor output
    task automatic t_disabled;
        ap.pulse(1'b1, 1'b0, 6'h05, 8'h5A, 1'b0, 1'b0, 6'h00);
        rd(6'h05);
        ap.pulse(1'b0, 1'b0, 6'h00, 8'h00, 1'b1, 1'b0, 6'h11);
        check({7'h00, readStrobe}, 8'h00);
        check(readData, word_of(6'h05));
    endtask

    // Write and read on one edge, mixed polarity: old word returns
    task automatic t_collide;
        logic [7:0] old;
        ap.set_pol(1'b0, 1'b1);
        old = word_of(6'h09);
        ap.pulse(1'b1, 1'b1, 6'h09, 8'h96, 1'b1, 1'b1, 6'h09);
        check(readData, old);
        nib[6'h12] = 4'h6;
        nib[6'h13] = 4'h9;
        rd(6'h29);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        err_total = 0;
        comparisons = 0;
        widthMode = dpram_pkg::WIDTH_X4;
        arst_n = 1'b0;
        repeat (8) @(negedge core_clk);
        t_reset();
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        t_reset();
        t_fill_x4();
        t_x8_fall();
        t_disabled();
        t_collide();
        close_out();
    end

    // Watchdog, well beyond the roughly 350 cycles needed
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        close_out();
    end
endmodule
